/* logic_ops_pkg.sv */
package logic_ops_pkg;
   // instruction bytes
   localparam logic [7:0] PREFIX_ED     = 8'hED;
   localparam logic [7:0] TEST_IMM_OP   = 8'h64;
   localparam logic [7:0] TEST_MEM_OP   = 8'h34;
   localparam logic [7:0] IO_TEST_OP    = 8'h74;
   localparam logic [7:0] XOR_REG_BASE  = 8'hA8;
   localparam logic [7:0] XOR_MEM_OP    = 8'hAE;
   localparam logic [7:0] XOR_IMM_OP    = 8'hEE;
   localparam logic [7:0] XOR_IDX_BASE  = 8'hAC;
   localparam logic [7:0] IDX_PFX_FIRST = 8'hDD;
   localparam logic [7:0] IDX_PFX_SECND = 8'hFD;
   localparam logic [7:0] WXOR_PAIR_BASE = 8'hAC;
   localparam logic [7:0] WXOR_IDX_OP   = 8'hAF;
   // operand source selection codes
   localparam logic [2:0] SRC_REG  = 3'h0;
   localparam logic [2:0] SRC_IMM  = 3'h1;
   localparam logic [2:0] SRC_MEM  = 3'h2;
   localparam logic [2:0] SRC_IDXB = 3'h3;
   localparam logic [2:0] SRC_IO   = 3'h4;
   localparam logic [2:0] SRC_PAIR = 3'h5;
   // flag bit positions
   localparam int FLAG_C = 0;
   localparam int FLAG_N = 1;
   localparam int FLAG_P = 2;
   localparam int FLAG_H = 4;
   localparam int FLAG_Z = 6;
   localparam int FLAG_S = 7;
   // execute cycles
   localparam logic [3:0] IO_TEST_BASE_CYC = 4'h3;
   localparam logic [3:0] MEM_BASE_CYC   = 4'h2;
   localparam logic [3:0] IDX_BASE_CYC   = 4'h4;
   localparam logic [3:0] SHORT_CYC      = 4'h2;
endpackage

/* logic_flag_gen.sv */
`timescale 1ns/1ns
// combinational flags for byte/word logic results
module logic_flag_gen
   import logic_ops_pkg::*;
(
   input  wire logic [15:0] result_in,  // logic result
   input  wire logic        word_in,    // 1 = 16-bit result
   input  wire logic        half_in,    // half-carry value to report
   output logic      [7:0]  flags_out   // S Z - H - P N C
);
   logic [15:0] masked;
   // upper byte ignored for byte results
   always_comb begin
      masked = word_in ? result_in : {8'h00, result_in[7:0]};
      flags_out = 8'h00;
      flags_out[FLAG_S] = word_in ? masked[15] : masked[7];
      flags_out[FLAG_Z] = (masked == 16'h0000);
      flags_out[FLAG_H] = half_in;
      flags_out[FLAG_P] = ~(^masked);
   end
endmodule // logic_flag_gen

/* logic_test_and_xor_ops.sv */
`timescale 1ns/1ns
module logic_test_and_xor_ops
   import logic_ops_pkg::*;
(
   input  wire logic        CLK_IN,          // core clock
   input  wire logic        RESETN_IN,       // async reset, active low
   input  wire logic        START_IN,        // decoded instruction valid pulse
   input  wire logic [7:0]  PREFIX_IN,       // first byte, or 00 when none
   input  wire logic [7:0]  OPCODE_IN,       // opcode byte
   input  wire logic [15:0] IMM_IN,          // immediate byte or word
   input  wire logic [7:0]  ACC_IN,          // accumulator
   input  wire logic [7:0]  REG8_IN,         // register selected by r field
   input  wire logic [7:0]  MEM_IN,          // memory operand byte
   input  wire logic [15:0] MEMW_IN,         // memory operand word
   input  wire logic        MEM_RDY_IN,      // memory operand valid
   input  wire logic [15:0] PRIMARY_PAIR_ACCUMULATOR_IN, // pair accumulator
   input  wire logic [15:0] FIRST_GENERAL_PAIR_IN,       // first pair
   input  wire logic [15:0] SECOND_GENERAL_PAIR_IN,      // second pair
   input  wire logic [15:0] FIRST_INDEX_REGISTER_IN,     // first index register
   input  wire logic [15:0] SECOND_INDEX_REGISTER_IN,    // second index register
   input  wire logic [7:0]  C_REG_IN,        // register C
   input  wire logic [7:0]  IO_DATA_IN,      // internal I/O read data
   input  wire logic        IO_RDY_IN,       // internal I/O read done
   input  wire logic [7:0]  FLAGS_IN,        // current flags
   output logic             BUSY_OUT,        // operation in progress
   output logic             DONE_OUT,        // one-cycle commit pulse
   output logic             ACC_WE_OUT,      // accumulator write
   output logic [7:0]       ACC_OUT,         // new accumulator
   output logic             PAIR_WE_OUT,     // pair accumulator write
   output logic [15:0]      PAIR_OUT,        // new pair accumulator
   output logic [7:0]       FLAGS_OUT,       // new flags
   output logic             IO_INT_RD_OUT,   // internal I/O read strobe
   output logic             IO_EXT_REQ_OUT,  // external I/O request, always low
   output logic [31:0]      ADDR_OUT,        // address bus drive
   output logic [3:0]       CYCLES_OUT,      // execute cycle count of last op
   output logic             ILLEGAL_OUT      // unrecognised opcode pulse
);
   typedef enum logic [2:0] {
      ST_IDLE = 3'b001,
      ST_WAIT = 3'b010,
      ST_DONE = 3'b100
   } state_e;

   typedef enum logic [1:0] {
      OP_BTEST = 2'h0, OP_IOTEST = 2'h1, OP_BXOR = 2'h2, OP_WXOR = 2'h3
   } op_e;

   typedef struct packed {
      state_e      state;
      op_e         op;
      logic [2:0]  src;
      logic [15:0] operand;
      logic [3:0]  cnt;
      logic        busy;
      logic        done;
      logic        acc_we;
      logic [7:0]  acc;
      logic        pair_we;
      logic [15:0] pair;
      logic [7:0]  flags;
      logic        io_rd;
      logic [31:0] addr;
      logic [3:0]  cycles;
      logic        illegal;
   } state_s;

   state_s      cur;
   state_s      next_cur;
   logic [15:0] result;
   logic        word_op;
   logic        half_val;
   logic [7:0]  gen_flags;
   logic [15:0] idx_word;

   // index register chosen by the y bit of the prefix
   function automatic logic [15:0] pick_index(input logic [7:0] pfx,
                                              input logic [15:0] xa,
                                              input logic [15:0] xb);
      pick_index = pfx[5] ? xb : xa;
   endfunction

   // chosen index register, shared by the byte and word index forms
   assign idx_word = pick_index(PREFIX_IN, FIRST_INDEX_REGISTER_IN, SECOND_INDEX_REGISTER_IN);

   // operand-ready value combined with accumulator, pair or I/O read data
   always_comb begin
      word_op  = (cur.op == OP_WXOR);
      half_val = (cur.op == OP_BTEST) || (cur.op == OP_IOTEST);
      case (cur.op)
         OP_BTEST:  result = {8'h00, ACC_IN & cur.operand[7:0]};
         OP_IOTEST: result = {8'h00, IO_DATA_IN & cur.operand[7:0]};
         OP_BXOR:   result = {8'h00, ACC_IN ^ cur.operand[7:0]};
         default:   result = PRIMARY_PAIR_ACCUMULATOR_IN ^ cur.operand;
      endcase
   end

   logic_flag_gen u_flags (
      .result_in (result),
      .word_in   (word_op),
      .half_in   (half_val),
      .flags_out (gen_flags)
   );

   // decode, wait for operand, commit result and flags together
   always_comb begin
      next_cur = cur;
      next_cur.done    = 1'b0;
      next_cur.acc_we  = 1'b0;
      next_cur.pair_we = 1'b0;
      next_cur.illegal = 1'b0;
      case (cur.state)
         ST_IDLE: begin
            if (START_IN) begin
               next_cur.state = ST_WAIT;
               next_cur.busy  = 1'b1;
               next_cur.cnt   = 4'h1;
               next_cur.src   = SRC_REG;
               next_cur.operand = {8'h00, REG8_IN};
               next_cur.cycles  = SHORT_CYC;
               if (PREFIX_IN == PREFIX_ED && OPCODE_IN == IO_TEST_OP) begin
                  next_cur.op  = OP_IOTEST;
                  next_cur.src = SRC_IO;
                  next_cur.operand = {8'h00, IMM_IN[7:0]};
                  next_cur.io_rd = 1'b1;
                  next_cur.addr  = {24'h000000, C_REG_IN};
                  next_cur.cycles = IO_TEST_BASE_CYC;
               end else if (PREFIX_IN == PREFIX_ED && OPCODE_IN[7:6] == 2'b00
                            && OPCODE_IN[2:0] == 3'b100) begin
                  next_cur.op = OP_BTEST;
                  if (OPCODE_IN == TEST_MEM_OP) begin
                     next_cur.src = SRC_MEM;
                     next_cur.cycles = MEM_BASE_CYC;
                  end
               end else if (PREFIX_IN == PREFIX_ED && OPCODE_IN == TEST_IMM_OP) begin
                  next_cur.op = OP_BTEST;
                  next_cur.operand = {8'h00, IMM_IN[7:0]};
               end else if (PREFIX_IN == PREFIX_ED && OPCODE_IN == XOR_MEM_OP) begin
                  next_cur.op = OP_WXOR;
                  next_cur.operand = IMM_IN;
               end else if (PREFIX_IN == PREFIX_ED && OPCODE_IN[7:2] == WXOR_PAIR_BASE[7:2]
                            && OPCODE_IN[1:0] != 2'b10) begin
                  next_cur.op = OP_WXOR;
                  next_cur.src = SRC_PAIR;
                  case (OPCODE_IN[1:0])
                     2'b00:   next_cur.operand = FIRST_GENERAL_PAIR_IN;
                     2'b01:   next_cur.operand = SECOND_GENERAL_PAIR_IN;
                     default: next_cur.operand = PRIMARY_PAIR_ACCUMULATOR_IN;
                  endcase
               end else if ((PREFIX_IN == IDX_PFX_FIRST) || (PREFIX_IN == IDX_PFX_SECND)) begin
                  next_cur.cycles = IDX_BASE_CYC;
                  if (OPCODE_IN == XOR_MEM_OP) begin
                     next_cur.op = OP_BXOR;
                     next_cur.src = SRC_MEM;
                  end else if (OPCODE_IN == XOR_IMM_OP) begin
                     next_cur.op = OP_WXOR;
                     next_cur.src = SRC_MEM;
                  end else if (OPCODE_IN == WXOR_IDX_OP) begin
                     next_cur.op = OP_WXOR;
                     next_cur.cycles = SHORT_CYC;
                     next_cur.operand = idx_word;
                  end else if (OPCODE_IN[7:1] == XOR_IDX_BASE[7:1]) begin
                     next_cur.op = OP_BXOR;
                     next_cur.cycles = SHORT_CYC;
                     next_cur.src = SRC_IDXB;
                     // w=0 high byte, w=1 low byte
                     next_cur.operand = OPCODE_IN[0] ? {8'h00, idx_word[7:0]}
                                                     : {8'h00, idx_word[15:8]};
                  end else begin
                     next_cur.state = ST_IDLE;
                     next_cur.busy = 1'b0;
                     next_cur.illegal = 1'b1;
                  end
               end else if (PREFIX_IN == 8'h00 && OPCODE_IN[7:3] == XOR_REG_BASE[7:3]) begin
                  next_cur.op = OP_BXOR;
                  if (OPCODE_IN == XOR_MEM_OP) begin
                     next_cur.src = SRC_MEM;
                     next_cur.cycles = MEM_BASE_CYC;
                  end
               end else if (PREFIX_IN == 8'h00 && OPCODE_IN == XOR_IMM_OP) begin
                  next_cur.op = OP_BXOR;
                  next_cur.operand = {8'h00, IMM_IN[7:0]};
               end else begin
                  next_cur.state = ST_IDLE;
                  next_cur.busy = 1'b0;
                  next_cur.illegal = 1'b1;
               end
            end
         end
         ST_WAIT: begin
            // waits only count up cnt; CYCLES_OUT keeps its base value
            if (cur.src == SRC_MEM && !MEM_RDY_IN) begin
               next_cur.cnt = cur.cnt + 4'h1;
            end else if (cur.src == SRC_IO && !IO_RDY_IN) begin
               next_cur.cnt = cur.cnt + 4'h1;
            end else begin
               next_cur.state = ST_DONE;
               if (cur.src == SRC_MEM) begin
                  next_cur.operand = (cur.op == OP_WXOR) ? MEMW_IN : {8'h00, MEM_IN};
               end
            end
         end
         ST_DONE: begin
            // flags and result land in one cycle
            next_cur.state   = ST_IDLE;
            next_cur.busy    = 1'b0;
            next_cur.done    = 1'b1;
            next_cur.io_rd   = 1'b0;
            next_cur.addr    = 32'h00000000;
            next_cur.acc_we  = (cur.op == OP_BXOR);
            next_cur.pair_we = (cur.op == OP_WXOR);
            next_cur.acc     = result[7:0];
            next_cur.pair    = result;
            next_cur.flags   = {gen_flags[7:6], FLAGS_IN[5], gen_flags[4], FLAGS_IN[3],
                                gen_flags[2], 2'b00};
            if (cur.op == OP_BXOR) begin
               next_cur.flags[FLAG_N] = FLAGS_IN[FLAG_N];
               next_cur.flags[FLAG_C] = FLAGS_IN[FLAG_C];
            end
         end
         default: next_cur.state = ST_IDLE;
      endcase
   end

   // single state register
   always_ff @(posedge CLK_IN or negedge RESETN_IN) begin
      if (!RESETN_IN) begin
         cur <= '{state: ST_IDLE, op: OP_BTEST, default: '0};
      end else begin
         cur <= next_cur;
      end
   end

   assign BUSY_OUT       = cur.busy;
   assign DONE_OUT       = cur.done;
   assign ACC_WE_OUT     = cur.acc_we;
   assign ACC_OUT        = cur.acc;
   assign PAIR_WE_OUT    = cur.pair_we;
   assign PAIR_OUT       = cur.pair;
   assign FLAGS_OUT      = cur.flags;
   assign IO_INT_RD_OUT  = cur.io_rd;
   assign IO_EXT_REQ_OUT = 1'b0;
   assign ADDR_OUT       = cur.addr;
   assign CYCLES_OUT     = cur.cycles;
   assign ILLEGAL_OUT    = cur.illegal;

   // checks
   a_test_no_write: assert property (@(posedge CLK_IN) disable iff (!RESETN_IN)
      (DONE_OUT && cur.op == OP_BTEST) |-> !ACC_WE_OUT && !PAIR_WE_OUT)
      else $error("byte test wrote a register");
   a_io_addr_hi: assert property (@(posedge CLK_IN) disable iff (!RESETN_IN)
      IO_INT_RD_OUT |-> ADDR_OUT[31:8] == 24'h000000)
      else $error("upper address not zero");
   a_io_no_ext: assert property (@(posedge CLK_IN) disable iff (!RESETN_IN)
      !IO_EXT_REQ_OUT) else $error("external io started");
   a_io_flags: assert property (@(posedge CLK_IN) disable iff (!RESETN_IN)
      (DONE_OUT && cur.op == OP_IOTEST) |-> FLAGS_OUT[FLAG_H] && !FLAGS_OUT[FLAG_N]
      && !FLAGS_OUT[FLAG_C]) else $error("io test flags wrong");
   a_xor_half_clr: assert property (@(posedge CLK_IN) disable iff (!RESETN_IN)
      ACC_WE_OUT |-> !FLAGS_OUT[FLAG_H] && FLAGS_OUT[FLAG_Z] == (ACC_OUT == 8'h00))
      else $error("byte xor flags wrong");
   a_word_flags: assert property (@(posedge CLK_IN) disable iff (!RESETN_IN)
      PAIR_WE_OUT |-> FLAGS_OUT[FLAG_S] == PAIR_OUT[15] && !FLAGS_OUT[FLAG_C]
      && FLAGS_OUT[FLAG_P] == ~(^PAIR_OUT)) else $error("word xor flags wrong");
   a_commit_pulse: assert property (@(posedge CLK_IN) disable iff (!RESETN_IN)
      (ACC_WE_OUT || PAIR_WE_OUT) |-> DONE_OUT ##1 !DONE_OUT)
      else $error("write not aligned with commit");
   a_io_start: assert property (@(posedge CLK_IN) disable iff (!RESETN_IN)
      (START_IN && !BUSY_OUT && PREFIX_IN == PREFIX_ED && OPCODE_IN == IO_TEST_OP)
      |=> IO_INT_RD_OUT && CYCLES_OUT == IO_TEST_BASE_CYC)
      else $error("io test decode wrong");
   c_xor: cover property (@(posedge CLK_IN) ACC_WE_OUT);
   c_word_xor: cover property (@(posedge CLK_IN) PAIR_WE_OUT);
   c_io_test: cover property (@(posedge CLK_IN) DONE_OUT && cur.op == OP_IOTEST);
   c_illegal: cover property (@(posedge CLK_IN) ILLEGAL_OUT);
endmodule // logic_test_and_xor_ops

/* testbench.sv */
`timescale 1ns/1ns
module testbench
   import logic_ops_pkg::*;
;
   logic        clk, resetn, start, mrdy, iordy;
   logic [7:0]  pfx, opc, acc, r8, mem, creg, iod, fin, src, res;
   logic [15:0] imm, memw, pacc, gp1, gp2, xr1, xr2, w16, wr;
   logic        busy, done, acc_we, pair_we, io_rd, io_ext, ill;
   logic [7:0]  acc_o, fl_o;
   logic [15:0] pair_o;
   logic [31:0] addr;
   logic [3:0]  cyc;
   int          n_errors, checked, n_done;

   logic_test_and_xor_ops logic_test_and_xor_ops_inst (
      .CLK_IN(clk), .RESETN_IN(resetn), .START_IN(start), .PREFIX_IN(pfx), .OPCODE_IN(opc),
      .IMM_IN(imm), .ACC_IN(acc), .REG8_IN(r8), .MEM_IN(mem), .MEMW_IN(memw),
      .MEM_RDY_IN(mrdy), .PRIMARY_PAIR_ACCUMULATOR_IN(pacc), .FIRST_GENERAL_PAIR_IN(gp1),
      .SECOND_GENERAL_PAIR_IN(gp2), .FIRST_INDEX_REGISTER_IN(xr1),
      .SECOND_INDEX_REGISTER_IN(xr2), .C_REG_IN(creg), .IO_DATA_IN(iod), .IO_RDY_IN(iordy),
      .FLAGS_IN(fin), .BUSY_OUT(busy), .DONE_OUT(done), .ACC_WE_OUT(acc_we), .ACC_OUT(acc_o),
      .PAIR_WE_OUT(pair_we), .PAIR_OUT(pair_o), .FLAGS_OUT(fl_o), .IO_INT_RD_OUT(io_rd),
      .IO_EXT_REQ_OUT(io_ext), .ADDR_OUT(addr), .CYCLES_OUT(cyc), .ILLEGAL_OUT(ill));

   // free-running core clock, 100 MHz
   initial clk = 1'b0;
   always #5 clk = ~clk;

   // count commit pulses so a swallowed or doubled request shows up
   always @(posedge clk) if (done === 1'b1) n_done++;

   task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
      checked++;
      if (got !== exp) begin
         n_errors++;
         $display("wrong value %s expected %h seen %h", what, exp, got);
      end
   endtask

   // expected flags; bits 5 and 3 always pass through from the flag input
   function automatic logic [7:0] efl(input logic [15:0] r, input bit w, input bit h,
                                      input bit keep);
      logic [7:0] f;
      f = fin & 8'h28;
      f[FLAG_S] = w ? r[15] : r[7];
      f[FLAG_Z] = w ? (r == 16'h0) : (r[7:0] == 8'h0);
      f[FLAG_H] = h;
      f[FLAG_P] = w ? ~^r : ~^r[7:0];
      if (keep) begin
         f[FLAG_N] = fin[FLAG_N];
         f[FLAG_C] = fin[FLAG_C];
      end
      return f;
   endfunction

   // one instruction; operand ready is held back dly cycles to exercise the wait state
   task automatic go(input logic [7:0] p, input logic [7:0] o, input int dly, input bit io);
      int k;
      @(posedge clk); #1;
      start = 1'b1;
      pfx = p;
      opc = o;
      mrdy = (dly == 0);
      iordy = (dly == 0);
      @(posedge clk); #1;
      start = 1'b0;
      k = 1;
      while (done !== 1'b1 && k < 40) begin
         if (io) begin
            chk("io read strobe", 32'h1, io_rd);
            chk("io address", {24'h0, creg}, addr);
         end
         chk("external io request", 32'h0, io_ext);
         if (k == dly) begin
            mrdy = 1'b1;
            iordy = 1'b1;
         end
         @(posedge clk); #1;
         k++;
      end
      chk("done", 32'h1, done);
   endtask

   task automatic test_byte_and();
      for (int i = 0; i < 9; i++) begin
         acc = 8'h96 ^ 8'(i);
         r8 = 8'h69 ^ 8'(i);
         mem = 8'hF3 ^ 8'(i);
         imm = {8'hAA, 8'hC5 ^ 8'(i)};
         fin = 8'(i * 43);
         src = (i == 6) ? mem : (i == 8) ? imm[7:0] : r8;
         res = acc & src;
         go(PREFIX_ED, (i == 8) ? TEST_IMM_OP : {2'b00, 3'(i), 3'b100}, (i == 6) ? 2 : 0, 0);
         chk("and test flags", efl({8'h0, res}, 0, 1, 0), fl_o);
         chk("and test acc write", 32'h0, acc_we);
         chk("and test pair write", 32'h0, pair_we);
         chk("and test cycles", (i == 6) ? MEM_BASE_CYC : SHORT_CYC, cyc);
      end
      $display("test_byte_and finished");
   endtask

   task automatic test_io_and();
      for (int i = 0; i < 3; i++) begin
         creg = 8'h9C ^ 8'(i * 85);
         iod = 8'hE7 ^ 8'(i * 17);
         imm = {8'h55, 8'hB1 ^ 8'(i * 96)};
         fin = 8'hFF ^ 8'(i);
         res = iod & imm[7:0];
         go(PREFIX_ED, IO_TEST_OP, i * 2, 1);
         chk("io test flags", efl({8'h0, res}, 0, 1, 0), fl_o);
         chk("io test acc write", 32'h0, acc_we);
         chk("io test pair write", 32'h0, pair_we);
         chk("io test cycles", 32'(IO_TEST_BASE_CYC), 32'(cyc));
         chk("io address released", 32'h0, addr);
      end
      $display("test_io_and finished");
   endtask

   task automatic test_xor_byte();
      int j;
      for (int i = 0; i < 15; i++) begin
         j = i - 9;
         acc = 8'hC3 ^ 8'(i);
         r8 = 8'hC3 ^ 8'(i * 3);
         mem = 8'h5E ^ 8'(i);
         imm = {8'h77, 8'h1B ^ 8'(i * 9)};
         xr1 = 16'h8421 ^ 16'(i * 257);
         xr2 = 16'h3CF0 ^ 16'(i * 4369);
         fin = 8'(i * 29);
         w16 = j[1] ? xr2 : xr1;
         src = (i == 6 || i > 12) ? mem : (i == 8) ? imm[7:0] : (i < 8) ? r8 :
               j[0] ? w16[7:0] : w16[15:8];
         res = acc ^ src;
         if (i < 8) go(8'h00, XOR_REG_BASE | 8'(i), (i == 6) ? 2 : 0, 0);
         else if (i == 8) go(8'h00, XOR_IMM_OP, 0, 0);
         else if (i < 13) go(j[1] ? IDX_PFX_SECND : IDX_PFX_FIRST, XOR_IDX_BASE | 8'(j[0]), 0, 0);
         else go(i[0] ? IDX_PFX_FIRST : IDX_PFX_SECND, XOR_MEM_OP, 2, 0);
         chk("xor result", res, acc_o);
         chk("xor acc write", 32'h1, acc_we);
         chk("xor pair write", 32'h0, pair_we);
         chk("xor flags", efl({8'h0, res}, 0, 0, 1), fl_o);
         chk("xor cycles", (i > 12) ? IDX_BASE_CYC : (i == 6) ? MEM_BASE_CYC : SHORT_CYC, cyc);
      end
      $display("test_xor_byte finished");
   endtask

   task automatic test_word_xor();
      for (int i = 0; i < 8; i++) begin
         pacc = 16'hA5C3 ^ 16'(i * 4097);
         gp1 = 16'h1234 ^ 16'(i);
         gp2 = 16'hFEDC ^ 16'(i);
         xr1 = 16'h0F0F ^ 16'(i * 3);
         xr2 = 16'h8001 ^ 16'(i * 5);
         imm = 16'h6699 ^ 16'(i * 7);
         memw = 16'hC0DE ^ 16'(i * 11);
         fin = 8'hFF ^ 8'(i * 37);
         w16 = (i == 0) ? gp1 : (i == 1) ? gp2 : (i == 2) ? pacc : (i == 3) ? imm :
               (i == 4) ? xr1 : (i == 5) ? xr2 : memw;
         wr = pacc ^ w16;
         if (i < 3) go(PREFIX_ED, WXOR_PAIR_BASE | 8'((i == 2) ? 3 : i), 0, 0);
         else if (i == 3) go(PREFIX_ED, XOR_MEM_OP, 0, 0);
         else if (i < 6) go(i[0] ? IDX_PFX_SECND : IDX_PFX_FIRST, WXOR_IDX_OP, 0, 0);
         else go(i[0] ? IDX_PFX_SECND : IDX_PFX_FIRST, XOR_IMM_OP, 2, 0);
         chk("word xor result", wr, pair_o);
         chk("word xor pair write", 32'h1, pair_we);
         chk("word xor acc write", 32'h0, acc_we);
         chk("word xor flags", efl(wr, 1, 0, 0), fl_o);
         chk("word xor cycles", (i > 5) ? IDX_BASE_CYC : SHORT_CYC, cyc);
      end
      $display("test_word_xor finished");
   endtask

   // a second request while busy must be dropped, not queued
   task automatic test_refuse();
      int d0;
      d0 = n_done;
      acc = 8'h0F;
      imm = 16'h00F0;
      r8 = 8'h33;
      fin = 8'h00;
      @(posedge clk); #1;
      start = 1'b1;
      pfx = 8'h00;
      opc = XOR_IMM_OP;
      @(posedge clk); #1;
      opc = XOR_REG_BASE;
      @(posedge clk); #1;
      start = 1'b0;
      repeat (8) @(posedge clk);
      #1;
      chk("commit count", 32'h1, n_done - d0);
      chk("refuse result", 32'hFF, acc_o);
      $display("test_refuse finished");
   endtask

   // unknown opcode pulses the flag; a reset in mid-operation clears everything
   task automatic test_illegal_reset();
      @(posedge clk); #1;
      start = 1'b1;
      pfx = 8'h00;
      opc = 8'h00;
      @(posedge clk); #1;
      start = 1'b0;
      chk("illegal pulse", 32'h1, 32'(ill));
      chk("illegal busy", 32'h0, 32'(busy));
      @(posedge clk); #1;
      chk("illegal pulse end", 32'h0, 32'(ill));
      creg = 8'h5A;
      iordy = 1'b0;
      start = 1'b1;
      pfx = PREFIX_ED;
      opc = IO_TEST_OP;
      @(posedge clk); #1;
      start = 1'b0;
      chk("io read before reset", 32'h1, 32'(io_rd));
      chk("io address before reset", {24'h0, creg}, addr);
      resetn = 1'b0;
      #1;
      chk("outputs in mid reset", 32'h0, 32'({busy, done, io_rd, acc_we, pair_we, ill}));
      chk("address in mid reset", 32'h0, addr);
      @(posedge clk); #1;
      resetn = 1'b1;
      $display("test_illegal_reset finished");
   endtask

   task automatic test_done();
      $display("comparisons %0d mismatches %0d", checked, n_errors);
      if (n_errors == 0 && checked > 0) begin
         $display("All checks passed");
      end else begin
         $display("Checks failed");
      end
      $finish;
   endtask

   // watchdog: the whole run needs well under 1000 cycles
   initial begin
      #50000;
      n_errors++;
      $display("wrong value watchdog expected finish seen timeout");
      test_done();
   end

   initial begin
      {resetn, start, mrdy, iordy} = 4'h0;
      {pfx, opc, acc, r8, mem, creg, iod, fin} = 64'h0;
      {imm, memw, pacc, gp1, gp2, xr1, xr2} = 112'h0;
      repeat (5) @(posedge clk);
      #1;
      chk("outputs in reset", 32'h0, 32'({busy, done, acc_we, pair_we, ill}));
      resetn = 1'b1;
      test_byte_and();
      test_io_and();
      test_xor_byte();
      test_word_xor();
      test_illegal_reset();
      test_refuse();
      test_done();
   end
endmodule // testbench
